// ==== trig_arm_defs.svh ====
// Constants for the trigger arming block
`ifndef TRIG_ARM_DEFS_SVH
`define TRIG_ARM_DEFS_SVH
// ==========================================================================
// Sequence numbers
`define SEQ_TRANSIENT     2'h1
`define SEQ_ACQUIRE       2'h2
// ==========================================================================
// Widths and reset values
`define LEVEL_W           16
`define LEVEL_RST         16'h0000
`define CONT_ARM_RST      1'b0
`endif

// ==== trig_arm_pkg.sv ====
// Types shared by the trigger arming block
package trig_arm_pkg;
   // Sequence state: idle or armed and waiting
   typedef enum logic [0:0] {
      SEQ_IDLE  = 1'b0,
      SEQ_ARMED = 1'b1
   } seq_state_t;
endpackage : trig_arm_pkg

// ==== seq_arm.sv ====
// One trigger sequence arming state machine
`include "trig_arm_defs.svh"
module seq_arm
   import trig_arm_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic resetn,
   input  wire logic cancel,
   input  wire logic arm_req,
   input  wire logic keep_armed,
   input  wire logic trig_req,
   output logic      fire,
   output logic      armed
);
   seq_state_t state_ff;
   seq_state_t nxt_state;
   // ======================================================================
   // Next state
   always_comb begin
      nxt_state = state_ff;
      fire      = 1'b0;
      unique case (state_ff)
         SEQ_IDLE: begin
            // Continuous arming survives a cancel; a plain initiate loses to it
            if (keep_armed || (!cancel && arm_req)) begin
               nxt_state = SEQ_ARMED;
            end
         end
         SEQ_ARMED: begin
            if (cancel) begin
               nxt_state = keep_armed ? SEQ_ARMED : SEQ_IDLE;
            end else if (trig_req) begin
               fire      = 1'b1;
               // Continuous mode re-arms straight away
               nxt_state = keep_armed ? SEQ_ARMED : SEQ_IDLE;
            end
         end
      endcase
   end
   // Reset behaves like an abort with keep_armed low: always back to idle
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_ff <= SEQ_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end
   assign armed = (state_ff == SEQ_ARMED);
endmodule : seq_arm

// ==== trigger_arming_control.sv ====
// Trigger arming and sequencing for transient and acquire sequences
`include "trig_arm_defs.svh"
// Operation
// - Sequence 1 transient, sequence 2 acquire
// - Abort cancels both sequences
// - Abort reloads pending levels from immediate
// - Abort clears waiting-for-trigger flag
// - Continuous mode re-arms after abort
// - Abort at reset, recall and reset command
// - Triggers ignored when sequence not armed
// - Armed sequence acts on its trigger
// - Continuous setting keeps transient armed
// - Transient trigger applies pending levels
// - Flag clears after both sequences complete
// - Flag is OR of both armed states
// - Continuous mode re-arms after trigger
// - Acquire trigger starts a measurement
// - Bus commands are the trigger source
module trigger_arming_control
   import trig_arm_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 resetn,
   input  wire logic                 abort_cmd,
   input  wire logic                 recall_cmd,
   input  wire logic                 reset_cmd,
   input  wire logic                 init_req,
   input  wire logic [1:0]           init_seq,
   input  wire logic                 trig_req,
   input  wire logic [1:0]           trig_seq,
   input  wire logic                 continuous_arm_setting,
   input  wire logic [`LEVEL_W-1:0]  imm_voltage_level,
   input  wire logic [`LEVEL_W-1:0]  imm_current_level,
   input  wire logic                 pend_load,
   input  wire logic [`LEVEL_W-1:0]  pend_voltage_in,
   input  wire logic [`LEVEL_W-1:0]  pend_current_in,
   output logic                      waiting_for_trigger_flag,
   output logic [`LEVEL_W-1:0]       pending_voltage_level,
   output logic [`LEVEL_W-1:0]       pending_current_level,
   output logic [`LEVEL_W-1:0]       out_voltage_level,
   output logic [`LEVEL_W-1:0]       out_current_level,
   output logic                      level_apply,
   output logic                      meas_start
);
   logic cancel;
   logic arm_tran;
   logic arm_acq;
   logic trig_tran;
   logic trig_acq;
   logic fire_tran;
   logic fire_acq;
   logic armed_tran;
   logic armed_acq;
   logic nxt_armed_tran;
   logic nxt_armed_acq;
   logic [`LEVEL_W-1:0] pend_v_ff;
   logic [`LEVEL_W-1:0] pend_i_ff;
   logic [`LEVEL_W-1:0] out_v_ff;
   logic [`LEVEL_W-1:0] out_i_ff;
   logic                wtg_ff;
   logic                apply_ff;
   logic                meas_ff;
   // ======================================================================
   // Command decode
   // Abort, recall and reset command all perform the same cancel
   assign cancel    = abort_cmd | recall_cmd | reset_cmd;
   // Sequence numbers select the target; bus commands are the only source
   assign arm_tran  = init_req & (init_seq == `SEQ_TRANSIENT);
   assign arm_acq   = init_req & (init_seq == `SEQ_ACQUIRE);
   assign trig_tran = trig_req & (trig_seq == `SEQ_TRANSIENT);
   assign trig_acq  = trig_req & (trig_seq == `SEQ_ACQUIRE);
   // ======================================================================
   // Sequence state machines
   // Transient only honours the continuous setting
   seq_arm u_tran (
      .sys_clk    (sys_clk),
      .resetn     (resetn),
      .cancel     (cancel),
      .arm_req    (arm_tran),
      .keep_armed (continuous_arm_setting),
      .trig_req   (trig_tran),
      .fire       (fire_tran),
      .armed      (armed_tran)
   );
   seq_arm u_acq (
      .sys_clk    (sys_clk),
      .resetn     (resetn),
      .cancel     (cancel),
      .arm_req    (arm_acq),
      .keep_armed (1'b0),
      .trig_req   (trig_acq),
      .fire       (fire_acq),
      .armed      (armed_acq)
   );
   // Next armed states, used to keep the flag in step with the machines
   always_comb begin
      nxt_armed_tran = armed_tran;
      nxt_armed_acq  = armed_acq;
      if (cancel) begin
         nxt_armed_tran = continuous_arm_setting;
         nxt_armed_acq  = 1'b0;
      end else begin
         if (!armed_tran && (arm_tran || continuous_arm_setting)) begin
            nxt_armed_tran = 1'b1;
         end else if (fire_tran) begin
            nxt_armed_tran = continuous_arm_setting;
         end
         if (!armed_acq && arm_acq) begin
            nxt_armed_acq = 1'b1;
         end else if (fire_acq) begin
            nxt_armed_acq = 1'b0;
         end
      end
   end
   // ======================================================================
   // Waiting-for-trigger flag, registered so it stays a clean output
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         wtg_ff <= 1'b0;
      end else begin
         // Clears only once neither sequence is still waiting
         wtg_ff <= nxt_armed_tran | nxt_armed_acq;
      end
   end
   // ======================================================================
   // Pending levels; abort discards any staged change
   // Power-on reset counts as an abort, so it reloads the staged levels too
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pend_v_ff <= imm_voltage_level;
         pend_i_ff <= imm_current_level;
      end else if (cancel) begin
         pend_v_ff <= imm_voltage_level;
         pend_i_ff <= imm_current_level;
      end else if (pend_load) begin
         pend_v_ff <= pend_voltage_in;
         pend_i_ff <= pend_current_in;
      end
   end
   // Output levels reset to zero and change only on a transient trigger, taking the pending levels
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         out_v_ff <= `LEVEL_RST;
         out_i_ff <= `LEVEL_RST;
         apply_ff <= 1'b0;
      end else begin
         apply_ff <= fire_tran;
         if (fire_tran) begin
            out_v_ff <= pend_v_ff;
            out_i_ff <= pend_i_ff;
         end
      end
   end
   // Measurement start pulse for the acquire side
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         meas_ff <= 1'b0;
      end else begin
         meas_ff <= fire_acq;
      end
   end
   assign waiting_for_trigger_flag = wtg_ff;
   assign pending_voltage_level    = pend_v_ff;
   assign pending_current_level    = pend_i_ff;
   assign out_voltage_level        = out_v_ff;
   assign out_current_level        = out_i_ff;
   assign level_apply              = apply_ff;
   assign meas_start               = meas_ff;
   // ======================================================================
   // Checks
   a_flag_is_or: assert property (@(posedge sys_clk) disable iff (!resetn)
      waiting_for_trigger_flag == (armed_tran | armed_acq))
      else $error("flag differs from armed OR");
   a_abort_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
      cancel && !continuous_arm_setting |=> !waiting_for_trigger_flag)
      else $error("abort left flag set");
   a_abort_rearm: assert property (@(posedge sys_clk) disable iff (!resetn)
      cancel && continuous_arm_setting |=> waiting_for_trigger_flag)
      else $error("continuous abort did not re-arm");
   a_abort_reload: assert property (@(posedge sys_clk) disable iff (!resetn)
      cancel |=> pending_voltage_level == $past(imm_voltage_level)
         && pending_current_level == $past(imm_current_level))
      else $error("pending levels not reloaded");
   a_abort_acq: assert property (@(posedge sys_clk) disable iff (!resetn)
      cancel |=> !armed_acq)
      else $error("abort left acquire armed");
   a_idle_ignore: assert property (@(posedge sys_clk) disable iff (!resetn)
      !armed_tran |=> !level_apply && $stable(out_voltage_level))
      else $error("trigger acted while idle");
   a_trig_apply: assert property (@(posedge sys_clk) disable iff (!resetn)
      armed_tran && trig_tran && !cancel |=> level_apply
         && out_voltage_level == $past(pending_voltage_level))
      else $error("transient trigger did not apply");
   a_init_sets: assert property (@(posedge sys_clk) disable iff (!resetn)
      arm_acq && !cancel |=> waiting_for_trigger_flag)
      else $error("initiate did not set flag");
   a_init_tran: assert property (@(posedge sys_clk) disable iff (!resetn)
      arm_tran && !cancel && !trig_req |=> waiting_for_trigger_flag)
      else $error("transient initiate did not set flag");
   a_cont_keeps: assert property (@(posedge sys_clk) disable iff (!resetn)
      continuous_arm_setting |=> waiting_for_trigger_flag)
      else $error("continuous setting left flag clear");
   a_flag_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
      armed_acq && !cancel && !trig_acq |=> waiting_for_trigger_flag)
      else $error("flag cleared while acquire waits");
   a_cont_rearm: assert property (@(posedge sys_clk) disable iff (!resetn)
      fire_tran && continuous_arm_setting |=> armed_tran)
      else $error("continuous mode did not re-arm");
   a_acq_meas: assert property (@(posedge sys_clk) disable iff (!resetn)
      armed_acq && trig_acq && !cancel |=> meas_start && !armed_acq)
      else $error("acquire trigger did not measure");
   // Cover points for the main scenarios
   c_tran_fire: cover property (@(posedge sys_clk) disable iff (!resetn)
      arm_tran ##[1:8] fire_tran);
   c_acq_fire: cover property (@(posedge sys_clk) disable iff (!resetn)
      arm_acq ##[1:8] fire_acq);
   c_abort_armed: cover property (@(posedge sys_clk) disable iff (!resetn)
      armed_tran && cancel);
   c_cont_burst: cover property (@(posedge sys_clk) disable iff (!resetn)
      continuous_arm_setting && fire_tran ##1 fire_tran);
   c_flag_overlap: cover property (@(posedge sys_clk) disable iff (!resetn)
      fire_tran && armed_acq);
endmodule : trigger_arming_control

// ==== host_ctrl_model.sv ====
// Remote host controller model that issues trigger commands
`include "trig_arm_defs.svh"
module host_ctrl_model (
   input  wire logic             sys_clk,
   output logic                  abort_cmd,
   output logic                  recall_cmd,
   output logic                  reset_cmd,
   output logic                  init_req,
   output logic [1:0]            init_seq,
   output logic                  trig_req,
   output logic [1:0]            trig_seq,
   output logic                  pend_load,
   output logic [`LEVEL_W-1:0]   pend_voltage_in,
   output logic [`LEVEL_W-1:0]   pend_current_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Command issue
   initial begin
      {abort_cmd, recall_cmd, reset_cmd, init_req, trig_req, pend_load} = 6'h00;
      {init_seq, trig_seq} = 4'h0;
      {pend_voltage_in, pend_current_in} = 32'h0000_0000;
   end
   // One command per cycle, held for one edge; kind 0 is idle
   task automatic issue(input int k, input logic [1:0] s, input logic [15:0] v, c);
      @(posedge sys_clk);
      #1;
      abort_cmd  = (k == 1);
      recall_cmd = (k == 2);
      reset_cmd  = (k == 3);
      init_req   = (k == 4);
      init_seq   = s;
      trig_req   = (k == 5);
      trig_seq   = s;
      pend_load  = (k == 6);
      // Idle data toggles so a stale value is never mistaken for a load
      pend_voltage_in = (k == 6) ? v : ~pend_voltage_in;
      pend_current_in = (k == 6) ? c : ~pend_current_in;
   endtask : issue
endmodule : host_ctrl_model

// ==== tb_trigger_arming_control.sv ====
// Self-checking bench for the trigger arming block
`include "trig_arm_defs.svh"
module tb_trigger_arming_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, resetn, abort_cmd, recall_cmd, reset_cmd, init_req, trig_req, pend_load;
   logic cont, flag, level_apply, meas_start, r_t, r_a, seen_rst;
   logic [1:0] init_seq, trig_seq;
   logic [15:0] imm_v, imm_c, pv_in, pc_in, pv, pc, ov, oc, r_pv, r_pc;
   logic [31:0] x = 32'hA007;
   logic [31:0] q_apply[$];
   int q_meas[$];
   int mismatches = 0, check_count = 0;
   trigger_arming_control dut (.sys_clk(sys_clk), .resetn(resetn), .abort_cmd(abort_cmd),
      .recall_cmd(recall_cmd), .reset_cmd(reset_cmd), .init_req(init_req), .init_seq(init_seq),
      .trig_req(trig_req), .trig_seq(trig_seq), .continuous_arm_setting(cont),
      .imm_voltage_level(imm_v), .imm_current_level(imm_c), .pend_load(pend_load),
      .pend_voltage_in(pv_in), .pend_current_in(pc_in), .waiting_for_trigger_flag(flag),
      .pending_voltage_level(pv), .pending_current_level(pc), .out_voltage_level(ov),
      .out_current_level(oc), .level_apply(level_apply), .meas_start(meas_start));
   host_ctrl_model host (.sys_clk(sys_clk), .abort_cmd(abort_cmd), .recall_cmd(recall_cmd),
      .reset_cmd(reset_cmd), .init_req(init_req), .init_seq(init_seq), .trig_req(trig_req),
      .trig_seq(trig_seq), .pend_load(pend_load), .pend_voltage_in(pv_in),
      .pend_current_in(pc_in));
   // ==========================================================
   // Helpers
   function automatic logic [31:0] rnd();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : rnd
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic go(int k, logic [1:0] s);
      host.issue(k, s, 16'(rnd()), 16'(rnd()));
   endtask : go
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report
   // ==========================================================
   // Clock and watchdog
   initial begin
      sys_clk = 0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      #40000;
      mismatches++;
      final_report();
   end
   // Expected state, noted as commands are taken; results go into queues
   always @(posedge sys_clk) begin
      // Reset acts as an abort, so staged levels follow the immediate ones
      if (!resetn) {r_t, r_a, r_pv, r_pc, seen_rst} = {2'h0, imm_v, imm_c, 1'b1};
      else if (abort_cmd | recall_cmd | reset_cmd) {r_pv, r_pc, r_t, r_a} = {imm_v, imm_c, cont, 1'b0};
      else begin
         if (pend_load) {r_pv, r_pc} = {pv_in, pc_in};
         if (trig_req && trig_seq == `SEQ_TRANSIENT && r_t) begin
            q_apply.push_back({r_pv, r_pc});
            r_t = cont;
         end else if ((init_req && init_seq == `SEQ_TRANSIENT) || cont) r_t = 1'b1;
         if (trig_req && trig_seq == `SEQ_ACQUIRE && r_a) begin
            q_meas.push_back(1);
            r_a = 1'b0;
         end else if (init_req && init_seq == `SEQ_ACQUIRE) r_a = 1'b1;
      end
   end
   // Watcher: registered outputs are settled by the falling edge
   always @(negedge sys_clk) if (seen_rst === 1'b1) begin
      check("flag", {15'h0, flag}, {15'h0, r_t | r_a});
      check("pending_v", pv, r_pv);
      check("pending_c", pc, r_pc);
      if (level_apply === 1'b1) begin
         check("apply_noted", 16'(q_apply.size() != 0), 16'h0001);
         if (q_apply.size() != 0) begin
            check("out_v", ov, q_apply[0][31:16]);
            check("out_c", oc, q_apply[0][15:0]);
            void'(q_apply.pop_front());
         end
      end
      if (meas_start === 1'b1) begin
         check("meas_noted", 16'(q_meas.size() != 0), 16'h0001);
         if (q_meas.size() != 0) void'(q_meas.pop_front());
      end
   end
   // ==========================================================
   // Scenarios
   initial begin
      {resetn, cont, seen_rst} = 3'h0;
      {imm_v, imm_c} = 32'h0;
      repeat (3) @(posedge sys_clk);
      #1 resetn = 1;
      // Triggers to idle sequences are dropped
      go(5, 1); go(5, 2);
      // Load, initiate, trigger back to back, then a trigger too many
      go(6, 0); go(4, 1); go(5, 1); go(5, 1);
      // Flag holds while acquire still waits
      go(4, 1); go(4, 2); go(5, 1); go(0, 0); go(5, 2);
      // Codes 0 and 3 name no sequence
      for (int s = 0; s < 4; s += 3) begin
         go(4, 2'(s)); go(5, 2'(s));
      end
      // Every abort source, continuous off then on
      for (int k = 1; k < 4; k++) for (int c = 0; c < 2; c++) begin
         go(6, 0); go(4, 1); go(4, 2);
         {imm_v, imm_c} = rnd();
         go(k, 0);
         cont = c[0];
         go(5, 1); go(5, 1); go(6, 0); go(5, 1); go(5, 2);
      end
      go(1, 0);
      cont = 0;
      // Reset in mid-run with acquire armed
      go(4, 2); go(0, 0);
      resetn = 0;
      repeat (3) @(posedge sys_clk);
      #1 resetn = 1;
      // Random traffic; continuous changes only with an abort
      repeat (300) begin
         automatic int k;
         k = int'(rnd() % 7);
         go(k, 2'(rnd()));
         if (k >= 1 && k <= 3) cont = ^rnd();
         {imm_v, imm_c} = rnd();
      end
      go(0, 0);
      repeat (3) @(posedge sys_clk);
      check("left", 16'(q_apply.size() + q_meas.size()), 16'h0);
      final_report();
   end
endmodule : tb_trigger_arming_control
